/* File: core/cgp_defines.svh */
// Timing, scaling and code constants for the current gauge PWM encoder.
// Assumes a 10 MHz core clock; all counts derive from the figures below.
`ifndef CGP_DEFINES_SVH
`define CGP_DEFINES_SVH

`define CGP_CLK_FREQ_HZ 10000000
`define CGP_SLOT_TIME_US 6000
`define CGP_SLOT_CYC ((`CGP_CLK_FREQ_HZ / 1000000) * `CGP_SLOT_TIME_US)
`define CGP_MOD_DIV 10
`define CGP_MOD_DIV_LAST 8'h09
`define CGP_PWM_FREQ_HZ 160
`define CGP_RAMP_STEPS 128
`define CGP_HALF_STEPS (2 * `CGP_RAMP_STEPS)
`define CGP_HALF_STEP_CYC (`CGP_CLK_FREQ_HZ / (`CGP_PWM_FREQ_HZ * `CGP_HALF_STEPS))
`define CGP_ZERO_CODE 7'h40
`define CGP_CODE_MAX 7'h7F
`define CGP_CODE_MID 64
`define CGP_IMAX_1A_MA 1000
`define CGP_IMAX_10A_MA 10000
`define CGP_GAIN_X10 22
`define CGP_SCALE_DEN 1280
`define CGP_SCALE_SHIFT 16

`endif

/* File: core/cgp_pkg.sv */
// Types shared by the current gauge PWM encoder modules.
// Constants live in cgp_defines.svh; this package holds types only.
`default_nettype none
package cgp_pkg;

	typedef enum logic [1:0] {
		CGP_MODE_HOLD = 2'b01,
		CGP_MODE_RUN = 2'b10
	} cgp_mode_e;

	typedef struct packed {
		logic [15:0] slot_cnt;
		logic [15:0] ones;
		logic [6:0] code;
		logic done;
	} cgp_filt_s;

	typedef struct packed {
		cgp_mode_e mode;
		logic [7:0] div;
		logic [7:0] step;
		logic [7:0] ramp;
		logic [6:0] held;
		logic pwm;
		logic strobe;
		logic [15:0] current;
	} cgp_top_s;

endpackage : cgp_pkg
`default_nettype wire

/* File: core/cgp_filter.sv */
// Slot-averaging filter for the modulator bitstream.
// Assumes sample_en pulses once per modulator bit and bit_in is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "cgp_defines.svh"

module cgp_filter #(
	parameter int SLOT_CYC = `CGP_SLOT_CYC
) (
	input wire logic clk, // Core clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic run, // High while measuring
	input wire logic sample_en, // One-cycle modulator sample strobe
	input wire logic bit_in, // Pulse-density bit
	output logic [6:0] code, // Averaged code of the last slot
	output logic done // One-cycle pulse at slot end
);

	localparam int SAMPLES = SLOT_CYC / `CGP_MOD_DIV;
	// Fixed-point reciprocal so no divider is needed per slot
	localparam int RECIP = ((`CGP_RAMP_STEPS << `CGP_SCALE_SHIFT) + SAMPLES / 2) / SAMPLES;
	localparam logic [15:0] SLOT_LAST = 16'(SLOT_CYC - 1);

	cgp_pkg::cgp_filt_s filt_reg;
	cgp_pkg::cgp_filt_s filt_next;

	function automatic logic [6:0] ones_to_code(input logic [15:0] ones);
		logic [31:0] prod;
		logic [31:0] q;
		prod = 32'(ones) * 32'(RECIP);
		q = prod >> `CGP_SCALE_SHIFT;
		// A full run of ones reaches 128 unless RECIP rounds down; clamp to the top code
		if (q > 32'(`CGP_CODE_MAX))
			ones_to_code = `CGP_CODE_MAX;
		else
			ones_to_code = q[6:0];
	endfunction : ones_to_code

	always_comb begin
		logic [15:0] ones_now;
		ones_now = filt_reg.ones;
		filt_next = filt_reg;
		filt_next.done = 1'b0;
		if (!run) begin
			filt_next.slot_cnt = 16'h0000;
			filt_next.ones = 16'h0000;
		end else begin
			if (sample_en && bit_in) begin
				ones_now = filt_reg.ones + 16'h0001;
			end
			if (filt_reg.slot_cnt == SLOT_LAST) begin
				filt_next.slot_cnt = 16'h0000;
				filt_next.ones = 16'h0000;
				filt_next.code = ones_to_code(ones_now);
				filt_next.done = 1'b1;
			end else begin
				filt_next.slot_cnt = filt_reg.slot_cnt + 16'h0001;
				filt_next.ones = ones_now;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			filt_reg <= '{slot_cnt: 16'h0000, ones: 16'h0000, code: `CGP_ZERO_CODE, done: 1'b0};
		end else begin
			filt_reg <= filt_next;
		end
	end

	assign code = filt_reg.code;
	assign done = filt_reg.done;

endmodule : cgp_filter
`default_nettype wire

/* File: core/cgp_pwm_encoder.sv */
// Current gauge back end: slot filter, held code, free-running ramp and PWM comparator.
// Assumes the modulator bit and the shutdown level are synchronous to clk.
//
// Contract
// - Filter the modulator bitstream into one multi-bit code per sampling slot.
// - PWM comes from comparing the held code with a free-running ramp.
// - Zero average current gives a 50 percent duty cycle.
// - Positive current drives duty above half, negative below half.
// - Full-scale positive gives 95.5 percent, full-scale negative 4.5 percent.
// - Duty equals current over 2.2 times full scale, plus one half.
// - Full scale is a fixed option, 1 A or 10 A, setting scaling.
// - Current is averaged over successive 6 ms slots.
// - Pulse width is quantised to 128 levels per period.
// - Duty for code N is N plus one half, over 128.
// - Duty in each slot shows the average of the previous slot.
// - Shutdown input low halts the device; high measures normally.
// - PWM repeats near 160 Hz, between 100 Hz and 250 Hz.
`timescale 1ns/1ps
`default_nettype none
`include "cgp_defines.svh"

module cgp_pwm_encoder #(
	parameter int SLOT_CYC = `CGP_SLOT_CYC, // Cycles per sampling slot
	parameter bit FULL_SCALE_10A = 1'b0 // Factory full-scale option
) (
	input wire logic clk, // Core clock, 10 MHz
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic low_power_hold_n, // Shutdown, low halts
	input wire logic mod_bit, // Modulator pulse-density bit
	output logic pwm_out, // Duty-coded current
	output logic [6:0] slot_code, // Code shown this slot
	output logic slot_strobe, // One-cycle pulse on new code
	output logic [15:0] current_ma, // Signed current of held code, mA
	output logic measuring // High while not in shutdown
);

	localparam logic [7:0] HALF_STEP_LAST = 8'(`CGP_HALF_STEP_CYC - 1);
	localparam int IMAX_MA = FULL_SCALE_10A ? `CGP_IMAX_10A_MA : `CGP_IMAX_1A_MA;

	cgp_pkg::cgp_top_s top_reg;
	cgp_pkg::cgp_top_s top_next;

	logic sample_en;
	logic filt_run;
	logic [6:0] filt_code;
	logic filt_done;

	// Current implied by a code, with the half-step offset removed as a reader would
	function automatic logic [15:0] code_to_ma(input logic [6:0] code);
		logic signed [31:0] delta;
		logic signed [31:0] prod;
		delta = $signed(32'(code)) - $signed(32'(`CGP_CODE_MID));
		// Every operand signed, so the division truncates toward zero for negative current
		prod = delta * $signed(32'(`CGP_GAIN_X10)) * $signed(32'(IMAX_MA));
		prod = prod / $signed(32'(`CGP_SCALE_DEN));
		code_to_ma = prod[15:0];
	endfunction : code_to_ma

	assign sample_en = (top_reg.div == `CGP_MOD_DIV_LAST);
	// Filter stops the same cycle the hold input drops, so no partial slot is published
	assign filt_run = (top_reg.mode == cgp_pkg::CGP_MODE_RUN) && low_power_hold_n;

	cgp_filter #(
		.SLOT_CYC(SLOT_CYC)
	) u_filter (
		.clk(clk),
		.rst_n(rst_n),
		.run(filt_run),
		.sample_en(sample_en),
		.bit_in(mod_bit),
		.code(filt_code),
		.done(filt_done)
	);

	always_comb begin
		top_next = top_reg;
		top_next.strobe = 1'b0;
		case (top_reg.mode)
			cgp_pkg::CGP_MODE_HOLD: begin
				top_next.div = 8'h00;
				top_next.step = 8'h00;
				top_next.ramp = 8'h00;
				top_next.held = `CGP_ZERO_CODE;
				top_next.pwm = 1'b0;
				top_next.current = 16'h0000;
				if (low_power_hold_n) begin
					top_next.mode = cgp_pkg::CGP_MODE_RUN;
				end
			end
			cgp_pkg::CGP_MODE_RUN: begin
				if (!low_power_hold_n) begin
					top_next.mode = cgp_pkg::CGP_MODE_HOLD;
					top_next.pwm = 1'b0;
					// Stale code would otherwise show for the first shutdown cycle
					top_next.held = `CGP_ZERO_CODE;
					top_next.current = 16'h0000;
				end else begin
					if (sample_en) begin
						top_next.div = 8'h00;
					end else begin
						top_next.div = top_reg.div + 8'h01;
					end
					// Ramp advances in half steps so the half-step offset needs no extra clock
					if (top_reg.step == HALF_STEP_LAST) begin
						top_next.step = 8'h00;
						top_next.ramp = top_reg.ramp + 8'h01;
					end else begin
						top_next.step = top_reg.step + 8'h01;
					end
					// High for 2N+1 of 256 half steps, duty (N+1/2)/128
					top_next.pwm = (top_reg.ramp < {top_reg.held, 1'b1});
					if (filt_done) begin
						// Only a slot end updates the comparator; mid-period jumps are accepted
						top_next.held = filt_code;
						top_next.strobe = 1'b1;
						top_next.current = code_to_ma(filt_code);
					end
				end
			end
			default: begin
				top_next.mode = cgp_pkg::CGP_MODE_HOLD;
				top_next.pwm = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			top_reg <= '{mode: cgp_pkg::CGP_MODE_HOLD, div: 8'h00, step: 8'h00, ramp: 8'h00,
				held: `CGP_ZERO_CODE, pwm: 1'b0, strobe: 1'b0, current: 16'h0000};
		end else begin
			top_reg <= top_next;
		end
	end

	assign pwm_out = top_reg.pwm;
	assign slot_code = top_reg.held;
	assign slot_strobe = top_reg.strobe;
	assign current_ma = top_reg.current;
	assign measuring = (top_reg.mode == cgp_pkg::CGP_MODE_RUN);

endmodule : cgp_pwm_encoder
`default_nettype wire

/* File: sim/cgp_pwm_properties.sv */
// Port checker for cgp_pwm_encoder.
// Assumes one clk domain; bound to every encoder.
`timescale 1ns/1ps
`default_nettype none
module cgp_pwm_properties #(
	parameter int SLOT_CYC = 600,
	parameter bit FULL_SCALE_10A = 1'b0
) (
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset
	input wire logic low_power_hold_n, // Shutdown
	input wire logic mod_bit, // Bitstream
	input wire logic pwm_out, // PWM
	input wire logic [6:0] slot_code, // Code
	input wire logic slot_strobe, // New code
	input wire logic [15:0] current_ma, // Current
	input wire logic measuring // Run
);
	localparam int IM = FULL_SCALE_10A ? 10000 : 1000;
	int gap;
	// Cycles since last strobe; -1 so the first slot counts like the rest
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) gap <= -1;
		else if (!measuring) gap <= -1;
		else if (slot_strobe) gap <= 1;
		else gap <= gap + 1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_hold_stops: assert property (!low_power_hold_n |=> !measuring && !pwm_out) else $error("hold");
	a_run_enter: assert property (low_power_hold_n |=> measuring) else $error("run");
	a_hold_code: assert property (!measuring |-> slot_code == 7'h40 && current_ma == 16'h0) else $error("code");
	a_strobe_pulse: assert property (slot_strobe |=> !slot_strobe) else $error("pulse");
	a_slot_period: assert property (measuring |-> slot_strobe == (gap == SLOT_CYC)) else $error("slot");
	a_code_stable: assert property (measuring && !slot_strobe |-> $stable(slot_code)) else $error("held");
	a_strobe_run: assert property (slot_strobe |-> $past(measuring, 2)) else $error("idle");
	a_current_map: assert property (measuring |->
		current_ma == 16'((int'(slot_code) - 64) * 22 * IM / 1280)) else $error("scale");
	c_full: cover property (slot_strobe && slot_code == 7'h7F);
	c_stop: cover property ($fell(measuring));
	c_pwm: cover property ($fell(pwm_out) && measuring);
	c_bits: cover property (measuring && mod_bit && slot_strobe);
endmodule : cgp_pwm_properties
bind cgp_pwm_encoder cgp_pwm_properties #(.SLOT_CYC(SLOT_CYC), .FULL_SCALE_10A(FULL_SCALE_10A)) cgp_pwm_properties_inst (
	.clk(clk), .rst_n(rst_n), .low_power_hold_n(low_power_hold_n), .mod_bit(mod_bit), .pwm_out(pwm_out),
	.slot_code(slot_code), .slot_strobe(slot_strobe), .current_ma(current_ma), .measuring(measuring));
`default_nettype wire

/* File: sim/cgp_duty_meter.sv */
// Duty meter in place of the reading controller.
// Measures the first full period after clr falls.
`timescale 1ns/1ps
`default_nettype none
module cgp_duty_meter (
	input wire logic clk, // Clock
	input wire logic clr, // Clear
	input wire logic pwm, // PWM
	output var int high_cnt, // High cycles
	output var int period_cnt, // Period
	output logic done // Done
);
	logic prev;
	int rises, r;
	always @(posedge clk) begin
		r = rises + int'(pwm && !prev);
		prev <= pwm;
		if (clr) begin
			rises <= 0;
			high_cnt <= 0;
			period_cnt <= 0;
		end else begin
			rises <= r;
			if (r == 1) begin
				period_cnt <= period_cnt + 1;
				high_cnt <= high_cnt + int'(pwm);
			end
		end
	end
	assign done = rises >= 2;
endmodule : cgp_duty_meter
`default_nettype wire

/* File: sim/tb_top.sv */
// Bench for cgp_pwm_encoder: slot codes, shutdown, one PWM period.
// Assumes SLOT_CYC 600, so 60 samples a slot.
`timescale 1ns/1ps
`default_nettype none
`include "cgp_defines.svh"
module tb_top;
	localparam int SC = 600;
	logic clk, rst_n, hold_n, mod_bit, clr, pwm_out, slot_strobe, measuring, done;
	logic [6:0] slot_code;
	logic [15:0] current_ma;
	int high_cnt, period_cnt, fail_count, samples_checked, cycles, ones, d;
	integer seed = 32'hc409;
	cgp_pwm_encoder #(.SLOT_CYC(SC)) cgp_pwm_encoder_inst (.clk(clk), .rst_n(rst_n), .low_power_hold_n(hold_n),
		.mod_bit(mod_bit), .pwm_out(pwm_out), .slot_code(slot_code), .slot_strobe(slot_strobe),
		.current_ma(current_ma), .measuring(measuring));
	cgp_duty_meter cgp_duty_meter_inst (.clk(clk), .clr(clr), .pwm(pwm_out), .high_cnt(high_cnt),
		.period_cnt(period_cnt), .done(done));
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	function automatic logic [6:0] exp_code(int n);
		int c;
		c = n * ((128 * 65536 + SC / 20) / (SC / 10)) / 65536;
		return (c > 127) ? 7'h7F : 7'(c);
	endfunction : exp_code
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s exp %0h got %0h", nm, e, g);
		end
	endtask : chk
	task report_and_stop;
		$display("checked %0d bad %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	// Run needs about 68000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 90000) begin
			fail_count++;
			report_and_stop();
		end
	end
	initial begin
		rst_n = 0;
		hold_n = 1;
		mod_bit = 0;
		clr = 1;
		repeat (12) @(negedge clk);
		rst_n = 1;
		d = 0;
		while (slot_strobe !== 1'b1 && d < 2000) begin
			@(negedge clk);
			d++;
		end
		// Bit held 10 cycles so each chunk meets exactly one sample
		for (int s = 0; s < 8; s++) begin
			d = (s == 0) ? 0 : (s == 1) ? 64 : ($random(seed) & 63);
			ones = 0;
			repeat (60) begin
				mod_bit = (($random(seed) & 63) < d);
				ones += mod_bit;
				repeat (10) @(negedge clk);
			end
			chk("strobe", 1, 32'(slot_strobe));
			chk("code", 32'(exp_code(ones)), 32'(slot_code));
			chk("cur", 32'($unsigned(16'((int'(exp_code(ones)) - 64) * 22000 / 1280))), 32'(current_ma));
		end
		$display("test slots done");
		hold_n = 0;
		repeat (2) @(negedge clk);
		chk("run", 0, 32'(measuring));
		chk("pwm", 0, 32'(pwm_out));
		chk("idle", 32'h40, 32'(slot_code));
		$display("test shutdown done");
		mod_bit = 1;
		hold_n = 1;
		clr = 0;
		d = 0;
		while (done !== 1'b1 && d < 70000) begin
			@(negedge clk);
			d++;
		end
		chk("high", 255 * `CGP_HALF_STEP_CYC, high_cnt);
		chk("period", `CGP_HALF_STEPS * `CGP_HALF_STEP_CYC, period_cnt);
		chk("reader", 127, (high_cnt * 256 - period_cnt) / (2 * period_cnt));
		$display("test duty done");
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
